// [lcs_pkg.sv]
// Shared constants, types and lookup tables for lane configuration control.
// Assumes one 50 MHz clock; strap levels arrive as comparator thermometers.
package lcs_pkg;

  // ==========================================================================
  // Sizes and strap indices
  localparam int LCS_NUM_SIDES   = 2;
  localparam int LCS_THERMO_W    = 3;
  localparam int LCS_NUM_STRAPS  = 12;
  localparam int LCS_S_EQ_DN_HI  = 0;
  localparam int LCS_S_EQ_DN_LO  = 1;
  localparam int LCS_S_EQ_UP_HI  = 2;
  localparam int LCS_S_EQ_UP_LO  = 3;
  localparam int LCS_S_DEM_DN_HI = 4;
  localparam int LCS_S_DEM_DN_LO = 5;
  localparam int LCS_S_DEM_UP_HI = 6;
  localparam int LCS_S_DEM_UP_LO = 7;
  localparam int LCS_S_MGMT      = 8;
  localparam int LCS_S_RECEIVER_DETECT_PINS     = 9;
  localparam int LCS_S_MODE      = 10;
  localparam int LCS_S_THRESH    = 11;
  localparam int LCS_OVR_BIT     = 7;
  localparam int LCS_LEVEL_MSB   = 1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    LCS_LVL_LOW, LCS_LVL_RES, LCS_LVL_FLOAT, LCS_LVL_HIGH
  } lcs_level_type;

  typedef enum logic [1:0] {
    LCS_SRC_PIN, LCS_SRC_SLAVE, LCS_SRC_MASTER
  } lcs_source_type;

  typedef enum logic [2:0] {
    LCS_FLD_EQ, LCS_FLD_SWING, LCS_FLD_DEEMPH, LCS_FLD_TERM_DIS,
    LCS_FLD_MODE, LCS_FLD_INPUT_EN, LCS_FLD_THRESH
  } lcs_field_type;

  typedef struct packed {
    logic [7:0] eq;
    logic [2:0] output_swing;
    logic [1:0] deemphasis_level;
    logic       term_dis;
  } lcs_lane_type;

  typedef struct packed {
    logic [1:0] mode;
    logic       mode_ovr;
    logic [1:0] input_en;
    logic       input_en_ovr;
    logic [1:0] thresh;
    logic       thresh_ovr;
  } lcs_global_type;

  typedef struct packed {
    logic          valid;
    lcs_field_type field;
    logic [1:0]    lane;
    logic [7:0]    data;
  } lcs_write_type;

  // ==========================================================================
  // Reset values
  localparam lcs_lane_type   LCS_LANE_RST = '0;
  localparam lcs_global_type LCS_GLB_RST  = '0;

  // ==========================================================================
  // Pin-mode tables, indexed by {hi strap, lo strap}
  localparam logic [7:0] LCS_EQ_TABLE [16] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0b, 8'h0f,
    8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf, 8'hff
  };
  // Swing code n is 0.6 V plus n times 0.1 V
  localparam logic [2:0] LCS_SWING_TABLE [16] = '{
    3'h0, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4,
    3'h4, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6
  };
  // Codes 0..3 are 0, -3.5, -6 and -9 dB
  localparam logic [1:0] LCS_DEEMPH_TABLE [16] = '{
    2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1,
    2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3
  };

endpackage

// [lcs_strap_decode.sv]
// Synchronises and decodes four-level strap comparator outputs.
// Assumes each strap gives three comparators at 0.2, 0.5 and 0.8 of supply.
module lcs_strap_decode #(
  parameter int NUM = 12
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_b,
  input  wire logic [NUM-1:0][lcs_pkg::LCS_THERMO_W-1:0] thermo,
  output lcs_pkg::lcs_level_type [NUM-1:0]            level
);

  // ==========================================================================
  // Per-strap synchroniser and level decode
  for (genvar g = 0; g < NUM; g++) begin : g_strap
    logic [lcs_pkg::LCS_THERMO_W-1:0] s1_r;
    logic [lcs_pkg::LCS_THERMO_W-1:0] s2_r;
    logic [lcs_pkg::LCS_THERMO_W-1:0] s1_nxt;
    logic [lcs_pkg::LCS_THERMO_W-1:0] s2_nxt;

    always_comb begin
      s1_nxt = thermo[g];
      s2_nxt = s1_r;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r <= '0;
        s2_r <= '0;
      end else begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
      end
    end

    // Highest tripped threshold wins
    always_comb begin
      if (s2_r[2])
        level[g] = lcs_pkg::LCS_LVL_HIGH;
      else if (s2_r[1])
        level[g] = lcs_pkg::LCS_LVL_FLOAT;
      else if (s2_r[0])
        level[g] = lcs_pkg::LCS_LVL_RES;
      else
        level[g] = lcs_pkg::LCS_LVL_LOW;
    end
  end

endmodule

// [lcs_side_lookup.sv]
// Maps one side's equaliser and de-emphasis strap pairs to lane settings.
// Assumes decoded, synchronised strap levels; purely combinational.
module lcs_side_lookup (
  input  lcs_pkg::lcs_level_type eq_hi,
  input  lcs_pkg::lcs_level_type eq_lo,
  input  lcs_pkg::lcs_level_type dem_hi,
  input  lcs_pkg::lcs_level_type dem_lo,
  output lcs_pkg::lcs_lane_type  setting
);

  // ==========================================================================
  // Two-digit strap index into the tables
  logic [3:0] eq_idx;
  logic [3:0] dem_idx;

  always_comb begin
    eq_idx                   = {eq_hi, eq_lo};
    dem_idx                  = {dem_hi, dem_lo};
    setting.eq               = lcs_pkg::LCS_EQ_TABLE[eq_idx];
    setting.output_swing     = lcs_pkg::LCS_SWING_TABLE[dem_idx];
    setting.deemphasis_level = lcs_pkg::LCS_DEEMPH_TABLE[dem_idx];
    setting.term_dis         = 1'b0;
  end

endmodule

// [lcs_config_top.sv]
// Control source selection, per-lane registers and pin overrides.
// Assumes the bus or EEPROM engine issues field writes on sys_clk.
module lcs_config_top #(
  parameter int LANES_PER_SIDE = 2
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst_b,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    eq_down_side_hi_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    eq_down_side_lo_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    eq_up_side_hi_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    eq_up_side_lo_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    deemph_down_side_hi_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    deemph_down_side_lo_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    deemph_up_side_hi_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    deemph_up_side_lo_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    mgmt_enable_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    receiver_detect_pins,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    mode_strap,
  input  wire logic [lcs_pkg::LCS_THERMO_W-1:0]    idle_threshold_pin,
  input  wire logic                                power_down_pin,
  input  wire logic [2*LANES_PER_SIDE-1:0]         rx_present,
  input  lcs_pkg::lcs_write_type                   cfg_write,
  output lcs_pkg::lcs_lane_type [2*LANES_PER_SIDE-1:0] lane_cfg,
  output logic [2*LANES_PER_SIDE-1:0]              term_on,
  output lcs_pkg::lcs_level_type                   proto_mode,
  output lcs_pkg::lcs_level_type                   idle_threshold,
  output lcs_pkg::lcs_source_type                  ctrl_source,
  output logic [3:0]                               slave_address_inputs
);

  localparam int NUM_LANES = lcs_pkg::LCS_NUM_SIDES * LANES_PER_SIDE;

  if (LANES_PER_SIDE < 1 || LANES_PER_SIDE > 2) begin : g_check
    $error("LANES_PER_SIDE must be 1 or 2");
  end

  // ==========================================================================
  // Strap decode
  lcs_pkg::lcs_level_type [lcs_pkg::LCS_NUM_STRAPS-1:0] lv;

  lcs_strap_decode #(
    .NUM    (lcs_pkg::LCS_NUM_STRAPS)
  ) u_decode (
    .sys_clk(sys_clk),
    .rst_b  (rst_b),
    .thermo ({idle_threshold_pin, mode_strap, receiver_detect_pins,
              mgmt_enable_strap, deemph_up_side_lo_strap,
              deemph_up_side_hi_strap, deemph_down_side_lo_strap,
              deemph_down_side_hi_strap, eq_up_side_lo_strap,
              eq_up_side_hi_strap, eq_down_side_lo_strap,
              eq_down_side_hi_strap}),
    .level  (lv)
  );

  // ==========================================================================
  // Pin synchronisers
  logic                 pd_s1_r;
  logic                 pd_s2_r;
  logic [NUM_LANES-1:0] rx_s1_r;
  logic [NUM_LANES-1:0] rx_s2_r;
  logic                 pd_s1_nxt;
  logic                 pd_s2_nxt;
  logic [NUM_LANES-1:0] rx_s1_nxt;
  logic [NUM_LANES-1:0] rx_s2_nxt;

  always_comb begin
    pd_s1_nxt = power_down_pin;
    pd_s2_nxt = pd_s1_r;
    rx_s1_nxt = rx_present;
    rx_s2_nxt = rx_s1_r;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
      rx_s1_r <= '0;
      rx_s2_r <= '0;
    end else begin
      pd_s1_r <= pd_s1_nxt;
      pd_s2_r <= pd_s2_nxt;
      rx_s1_r <= rx_s1_nxt;
      rx_s2_r <= rx_s2_nxt;
    end
  end

  // ==========================================================================
  // Control source
  lcs_pkg::lcs_source_type src;
  lcs_pkg::lcs_level_type  mgmt_lv;
  logic                    reg_mode;

  always_comb begin
    mgmt_lv = lv[lcs_pkg::LCS_S_MGMT];
    unique case (mgmt_lv)
      lcs_pkg::LCS_LVL_LOW:  src = lcs_pkg::LCS_SRC_PIN;
      lcs_pkg::LCS_LVL_HIGH: src = lcs_pkg::LCS_SRC_SLAVE;
      default:               src = lcs_pkg::LCS_SRC_MASTER;
    endcase
    reg_mode = (src != lcs_pkg::LCS_SRC_PIN);
  end

  // ==========================================================================
  // Configuration registers
  lcs_pkg::lcs_lane_type [NUM_LANES-1:0] lane_reg_r;
  lcs_pkg::lcs_lane_type [NUM_LANES-1:0] lane_reg_nxt;
  lcs_pkg::lcs_global_type               glb_r;
  lcs_pkg::lcs_global_type               glb_nxt;

  // Power-down is not an input here, so register contents survive it
  always_comb begin
    lane_reg_nxt = lane_reg_r;
    glb_nxt      = glb_r;
    if (!reg_mode) begin
      lane_reg_nxt = {NUM_LANES{lcs_pkg::LCS_LANE_RST}};
      glb_nxt      = lcs_pkg::LCS_GLB_RST;
    end else if (cfg_write.valid) begin
      unique case (cfg_write.field)
        lcs_pkg::LCS_FLD_EQ: begin
          if (int'(cfg_write.lane) < NUM_LANES)
            lane_reg_nxt[cfg_write.lane].eq = cfg_write.data;
        end
        lcs_pkg::LCS_FLD_SWING: begin
          if (int'(cfg_write.lane) < NUM_LANES)
            lane_reg_nxt[cfg_write.lane].output_swing =
              cfg_write.data[2:0];
        end
        lcs_pkg::LCS_FLD_DEEMPH: begin
          if (int'(cfg_write.lane) < NUM_LANES)
            lane_reg_nxt[cfg_write.lane].deemphasis_level =
              cfg_write.data[1:0];
        end
        lcs_pkg::LCS_FLD_TERM_DIS: begin
          if (int'(cfg_write.lane) < NUM_LANES)
            lane_reg_nxt[cfg_write.lane].term_dis = cfg_write.data[0];
        end
        lcs_pkg::LCS_FLD_MODE: begin
          glb_nxt.mode     = cfg_write.data[1:0];
          glb_nxt.mode_ovr = cfg_write.data[lcs_pkg::LCS_OVR_BIT];
        end
        lcs_pkg::LCS_FLD_INPUT_EN: begin
          glb_nxt.input_en     = cfg_write.data[1:0];
          glb_nxt.input_en_ovr = cfg_write.data[lcs_pkg::LCS_OVR_BIT];
        end
        lcs_pkg::LCS_FLD_THRESH: begin
          glb_nxt.thresh     = cfg_write.data[1:0];
          glb_nxt.thresh_ovr = cfg_write.data[lcs_pkg::LCS_OVR_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_reg_r <= {NUM_LANES{lcs_pkg::LCS_LANE_RST}};
      glb_r      <= lcs_pkg::LCS_GLB_RST;
    end else begin
      lane_reg_r <= lane_reg_nxt;
      glb_r      <= glb_nxt;
    end
  end

  // ==========================================================================
  // Pin-mode side settings
  lcs_pkg::lcs_lane_type [lcs_pkg::LCS_NUM_SIDES-1:0] side_set;

  lcs_side_lookup u_down (
    .eq_hi  (lv[lcs_pkg::LCS_S_EQ_DN_HI]),
    .eq_lo  (lv[lcs_pkg::LCS_S_EQ_DN_LO]),
    .dem_hi (lv[lcs_pkg::LCS_S_DEM_DN_HI]),
    .dem_lo (lv[lcs_pkg::LCS_S_DEM_DN_LO]),
    .setting(side_set[0])
  );

  lcs_side_lookup u_up (
    .eq_hi  (lv[lcs_pkg::LCS_S_EQ_UP_HI]),
    .eq_lo  (lv[lcs_pkg::LCS_S_EQ_UP_LO]),
    .dem_hi (lv[lcs_pkg::LCS_S_DEM_UP_HI]),
    .dem_lo (lv[lcs_pkg::LCS_S_DEM_UP_LO]),
    .setting(side_set[1])
  );

  // ==========================================================================
  // Effective settings and outputs
  lcs_pkg::lcs_lane_type [NUM_LANES-1:0] lane_cfg_r;
  lcs_pkg::lcs_lane_type [NUM_LANES-1:0] lane_cfg_nxt;
  logic [NUM_LANES-1:0]                  term_on_r;
  logic [NUM_LANES-1:0]                  term_on_nxt;
  lcs_pkg::lcs_level_type                proto_mode_r;
  lcs_pkg::lcs_level_type                proto_mode_nxt;
  lcs_pkg::lcs_level_type                idle_thr_r;
  lcs_pkg::lcs_level_type                idle_thr_nxt;
  lcs_pkg::lcs_level_type                inen_eff;
  lcs_pkg::lcs_source_type               src_r;
  logic [3:0]                            addr_r;
  logic [3:0]                            addr_nxt;
  logic [3:0]                            addr_pins;

  always_comb begin
    addr_pins = {lv[lcs_pkg::LCS_S_DEM_UP_LO][lcs_pkg::LCS_LEVEL_MSB],
                 lv[lcs_pkg::LCS_S_DEM_DN_LO][lcs_pkg::LCS_LEVEL_MSB],
                 lv[lcs_pkg::LCS_S_EQ_UP_LO][lcs_pkg::LCS_LEVEL_MSB],
                 lv[lcs_pkg::LCS_S_EQ_DN_LO][lcs_pkg::LCS_LEVEL_MSB]};
    addr_nxt = reg_mode ? addr_pins : 4'h0;
    proto_mode_nxt = (reg_mode && glb_r.mode_ovr) ?
      lcs_pkg::lcs_level_type'(glb_r.mode) : lv[lcs_pkg::LCS_S_MODE];
    idle_thr_nxt = (reg_mode && glb_r.thresh_ovr) ?
      lcs_pkg::lcs_level_type'(glb_r.thresh) :
      lv[lcs_pkg::LCS_S_THRESH];
    inen_eff = (reg_mode && glb_r.input_en_ovr) ?
      lcs_pkg::lcs_level_type'(glb_r.input_en) :
      lv[lcs_pkg::LCS_S_RECEIVER_DETECT_PINS];
    for (int i = 0; i < NUM_LANES; i++) begin
      lane_cfg_nxt[i] = reg_mode ? lane_reg_r[i] :
                        side_set[i / LANES_PER_SIDE];
      if (pd_s2_r || (reg_mode && lane_reg_r[i].term_dis)) begin
        term_on_nxt[i] = 1'b0;
      end else begin
        unique case (inen_eff)
          lcs_pkg::LCS_LVL_LOW:   term_on_nxt[i] = 1'b1;
          lcs_pkg::LCS_LVL_HIGH:  term_on_nxt[i] = 1'b1;
          lcs_pkg::LCS_LVL_FLOAT: term_on_nxt[i] = rx_s2_r[i];
          default:                term_on_nxt[i] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_cfg_r   <= {NUM_LANES{lcs_pkg::LCS_LANE_RST}};
      term_on_r    <= '0;
      proto_mode_r <= lcs_pkg::LCS_LVL_LOW;
      idle_thr_r   <= lcs_pkg::LCS_LVL_LOW;
      src_r        <= lcs_pkg::LCS_SRC_PIN;
      addr_r       <= 4'h0;
    end else begin
      lane_cfg_r   <= lane_cfg_nxt;
      term_on_r    <= term_on_nxt;
      proto_mode_r <= proto_mode_nxt;
      idle_thr_r   <= idle_thr_nxt;
      src_r        <= src;
      addr_r       <= addr_nxt;
    end
  end

  assign lane_cfg             = lane_cfg_r;
  assign term_on              = term_on_r;
  assign proto_mode           = proto_mode_r;
  assign idle_threshold       = idle_thr_r;
  assign ctrl_source          = src_r;
  assign slave_address_inputs = addr_r;

  // ==========================================================================
  // Checks
  logic [3:0]             eq_idx_dn;
  logic [3:0]             dem_idx_dn;
  lcs_pkg::lcs_level_type mode_pin;
  logic [1:0]             mode_reg;

  assign eq_idx_dn  = {lv[lcs_pkg::LCS_S_EQ_DN_HI], lv[lcs_pkg::LCS_S_EQ_DN_LO]};
  assign dem_idx_dn = {lv[lcs_pkg::LCS_S_DEM_DN_HI],
                       lv[lcs_pkg::LCS_S_DEM_DN_LO]};
  assign mode_pin   = lv[lcs_pkg::LCS_S_MODE];
  assign mode_reg   = glb_r.mode;

  logic ctrl_source_r_is_pin;
  assign ctrl_source_r_is_pin = (src_r == lcs_pkg::LCS_SRC_PIN);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  src_pin_a: assert property (mgmt_lv == lcs_pkg::LCS_LVL_LOW |=>
    ctrl_source_r_is_pin) else $error("low strap not pin mode");
  src_float_a: assert property (mgmt_lv == lcs_pkg::LCS_LVL_FLOAT |=>
    src_r == lcs_pkg::LCS_SRC_MASTER) else $error("float not master");
  pin_eq_a: assert property (!reg_mode |=>
    lane_cfg_r[0].eq == lcs_pkg::LCS_EQ_TABLE[$past(eq_idx_dn)])
    else $error("pin eq code wrong");
  swing_pair_a: assert property
    (!reg_mode && lcs_pkg::LCS_DEEMPH_TABLE[dem_idx_dn] != 2'h0 |=>
     lane_cfg_r[0].output_swing == lcs_pkg::LCS_SWING_TABLE[$past(dem_idx_dn)])
    else $error("swing not paired");
  reg_take_a: assert property (reg_mode |=>
    lane_cfg_r == $past(lane_reg_r)) else $error("regs not applied");
  addr_pins_a: assert property (reg_mode |=>
    addr_r == $past(addr_pins)) else $error("address not from straps");
  mode_pin_a: assert property (reg_mode && !glb_r.mode_ovr |=>
    proto_mode_r == $past(mode_pin)) else $error("mode pin ignored");
  mode_ovr_a: assert property (reg_mode && glb_r.mode_ovr |=>
    proto_mode_r == $past(mode_reg)) else $error("mode override lost");
  reg_reset_a: assert property (!reg_mode |=>
    lane_reg_r == {NUM_LANES{lcs_pkg::LCS_LANE_RST}})
    else $error("regs not reset");
  pd_hold_a: assert property (reg_mode && pd_s2_r && !cfg_write.valid |=>
    $stable(lane_reg_r) && $stable(glb_r)) else $error("regs lost");
  ovr_clear_a: assert property ($fell(reg_mode) |=>
    !glb_r.mode_ovr && !glb_r.input_en_ovr && !glb_r.thresh_ovr)
    else $error("override kept");
  pd_term_a: assert property (pd_s2_r |=> term_on_r == '0)
    else $error("termination on in power-down");

endmodule

// [lcs_host_model.sv]
// Behavioural bus or EEPROM engine issuing one field write per cycle.
// Assumes the bench queues writes into q; slow adds random stall cycles.
module lcs_host_model (
  input  wire logic              sys_clk,
  output lcs_pkg::lcs_write_type cfg_write
);
  timeunit 1ns;
  timeprecision 1ps;
  lcs_pkg::lcs_write_type q[$];
  lcs_pkg::lcs_write_type last;
  bit                     slow;
  initial begin
    slow = 1'b0;
    last = '0;
    cfg_write = '0;
  end
  // ==========================================================================
  // Drive just after the edge; idle cycles show the inverse of the last write
  always @(posedge sys_clk) begin
    #1;
    if (q.size() > 0 && !(slow && $urandom_range(1) == 1)) begin
      last = q.pop_front();
      cfg_write = last;
    end else begin
      cfg_write = ~last;
      cfg_write.valid = 1'b0;
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for lane configuration control.
// Assumes lcs_pkg and lcs_host_model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    lcs_pkg::lcs_lane_type [3:0] lane;
    logic [3:0]                  term;
    logic [1:0]                  mode, thr, src;
    logic [3:0]                  adr;
  } lcs_tb_exp_type;
  localparam logic [7:0] EQT [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07,
    8'h15, 8'h0b, 8'h0f, 8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf,
    8'hff};
  localparam logic [2:0] SWT [16] = '{3'h0, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6};
  localparam logic [1:0] DMT [16] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2,
    2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
  localparam int MG = lcs_pkg::LCS_S_MGMT;
  logic                        sys_clk, rst_b, pd, stb;
  logic [3:0]                  rxp, term_on, slave_address_inputs;
  logic [1:0]                  lv [12];
  lcs_pkg::lcs_write_type      cw;
  lcs_pkg::lcs_lane_type [3:0] lane_cfg;
  lcs_pkg::lcs_level_type      proto_mode, idle_threshold;
  lcs_pkg::lcs_source_type     ctrl_source;
  lcs_pkg::lcs_lane_type       rl [4];
  lcs_pkg::lcs_global_type     rg;
  lcs_tb_exp_type              exp_q[$], got, e;
  int                          n_errors, checks_done;
  function automatic logic [2:0] th(logic [1:0] l);
    return (l == 2'h3) ? 3'h7 : (l == 2'h2) ? 3'h3 : {2'h0, l == 2'h1};
  endfunction
  lcs_host_model host (.sys_clk(sys_clk), .cfg_write(cw));
  lcs_config_top #(.LANES_PER_SIDE(2)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .eq_down_side_hi_strap(th(lv[0])), .eq_down_side_lo_strap(th(lv[1])),
    .eq_up_side_hi_strap(th(lv[2])), .eq_up_side_lo_strap(th(lv[3])),
    .deemph_down_side_hi_strap(th(lv[4])),
    .deemph_down_side_lo_strap(th(lv[5])),
    .deemph_up_side_hi_strap(th(lv[6])), .deemph_up_side_lo_strap(th(lv[7])),
    .mgmt_enable_strap(th(lv[8])), .receiver_detect_pins(th(lv[9])),
    .mode_strap(th(lv[10])), .idle_threshold_pin(th(lv[11])),
    .power_down_pin(pd), .rx_present(rxp), .cfg_write(cw),
    .lane_cfg(lane_cfg), .term_on(term_on), .proto_mode(proto_mode),
    .idle_threshold(idle_threshold), .ctrl_source(ctrl_source),
    .slave_address_inputs(slave_address_inputs));
  assign got = {lane_cfg, term_on, proto_mode, idle_threshold, ctrl_source,
                slave_address_inputs};
  // ==========================================================================
  // Reference model of the expected outputs
  function automatic lcs_tb_exp_type model();
    lcs_tb_exp_type r;
    logic [3:0]     ei, di;
    logic [1:0]     ien;
    logic           rm;
    rm = lv[MG] != 2'h0;
    ien = (rm && rg.input_en_ovr) ? rg.input_en : lv[9];
    for (int k = 0; k < 4; k++) begin
      ei = {lv[2*(k/2)], lv[2*(k/2)+1]};
      di = {lv[4+2*(k/2)], lv[5+2*(k/2)]};
      r.lane[k] = rm ? rl[k] : {EQT[ei], SWT[di], DMT[di], 1'b0};
      r.term[k] = !pd && !(rm && rl[k].term_dis) &&
                  (ien == 2'h0 || ien == 2'h3 || (ien == 2'h2 && rxp[k]));
    end
    r.mode = (rm && rg.mode_ovr) ? rg.mode : lv[10];
    r.thr = (rm && rg.thresh_ovr) ? rg.thresh : lv[11];
    r.src = (lv[MG] == 2'h3) ? 2'h1 : rm ? 2'h2 : 2'h0;
    r.adr = rm ? {lv[7][1], lv[5][1], lv[3][1], lv[1][1]} : 4'h0;
    return r;
  endfunction
  task automatic clr();
    rl = '{default: '0};
    rg = '0;
  endtask
  task automatic wr(lcs_pkg::lcs_field_type f, int ln, logic [7:0] d);
    host.q.push_back('{1'b1, f, ln[1:0], d});
    if (lv[MG] != 2'h0) begin
      case (f)
        lcs_pkg::LCS_FLD_EQ: rl[ln].eq = d;
        lcs_pkg::LCS_FLD_SWING: rl[ln].output_swing = d[2:0];
        lcs_pkg::LCS_FLD_DEEMPH: rl[ln].deemphasis_level = d[1:0];
        lcs_pkg::LCS_FLD_TERM_DIS: rl[ln].term_dis = d[0];
        lcs_pkg::LCS_FLD_MODE: {rg.mode_ovr, rg.mode} = {d[7], d[1:0]};
        lcs_pkg::LCS_FLD_INPUT_EN: begin
          {rg.input_en_ovr, rg.input_en} = {d[7], d[1:0]};
        end
        default: {rg.thresh_ovr, rg.thresh} = {d[7], d[1:0]};
      endcase
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk();
    int n;
    n = 0;
    while (host.q.size() > 0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) begin
      n_errors++;
      $display("MISMATCH %0t host queue stuck", $time);
      stop_test();
    end
    repeat (4) @(posedge sys_clk);
    #1 exp_q.push_back(model());
    stb = 1'b1;
    @(posedge sys_clk);
    #1 stb = 1'b0;
  endtask
  // ==========================================================================
  // Monitor compares settled outputs against the oldest note
  always @(negedge sys_clk) begin
    if (stb) begin
      e = exp_q.pop_front();
      checks_done++;
      if (got !== e) begin
        n_errors++;
        $display("MISMATCH %0t got %h exp %h", $time, got, e);
      end
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    $display("MISMATCH %0t run timed out", $time);
    stop_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(88549));
    {rst_b, pd, stb, rxp, n_errors, checks_done} = '0;
    lv = '{default: 2'h0};
    clr();
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int k = 0; k < 32; k++) begin
      for (int j = 0; j < 12; j++) lv[j] = (j == MG) ? 2'h0 : 2'($urandom);
      {lv[0], lv[1], lv[6], lv[7]} = {k[3:0], k[3:0]};
      pd = (k % 8 == 7);
      rxp = 4'($urandom);
      chk();
    end
    pd = 1'b0;
    wr(lcs_pkg::LCS_FLD_EQ, 0, 8'h5a);
    lv[MG] = 2'h3;
    chk();
    for (int n = 0; n < 4; n++) begin
      for (int j = 0; j < 4; j++) wr(lcs_pkg::lcs_field_type'(j), n, 8'($urandom));
    end
    chk();
    for (int o = 0; o < 2; o++) begin
      for (int j = 4; j < 7; j++) begin
        wr(lcs_pkg::lcs_field_type'(j), 0, {o[0], 5'h0, 2'($urandom)});
      end
      chk();
      {lv[9], lv[10], lv[11], rxp} = {6'($urandom), 4'($urandom)};
      chk();
    end
    pd = 1'b1;
    chk();
    pd = 1'b0;
    host.slow = 1'b1;
    lv[MG] = 2'h2;
    for (int j = 0; j < 4; j++) wr(lcs_pkg::lcs_field_type'(j), j, 8'($urandom));
    chk();
    lv[MG] = 2'h1;
    chk();
    lv[MG] = 2'h0;
    clr();
    chk();
    lv[MG] = 2'h3;
    chk();
    for (int j = 0; j < 7; j++) wr(lcs_pkg::lcs_field_type'(j), 3, 8'hff);
    chk();
    rst_b = 1'b0;
    clr();
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    chk();
    stop_test();
  end
endmodule
